/* File: hw/sls_pkg.sv */
/*
 * package for the status indicator sequencer: register map, field
 * positions, reset values and the timing constants of the flash patterns.
 * assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package sls_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned TICK_HZ      = 1_000;                  // pattern timebase, 1 ms steps
   localparam int unsigned TICK_CYC     = CLK_HZ / TICK_HZ;       // cycles per ms
   localparam int unsigned WHITE_MS     = 50;                     // rapid white half period
   localparam int unsigned RED_ON_MS    = 150;                    // short red flash
   localparam int unsigned RED_GAP_MS   = 150;                    // gap between red flashes
   localparam int unsigned PAUSE_MS     = 1_000;                  // pause after a red group
   localparam int unsigned GREEN_ON_MS  = 150;                    // heartbeat flash
   localparam int unsigned GREEN_PER_MS = 4_000;                  // heartbeat period
   localparam int unsigned BLUE_ON_MS   = 300;                    // trigger flash

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_ST = 8'h08;
   localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
   localparam logic [7:0] OFS_IRQ_CL = 8'h10;

   // ctrl fields
   localparam int unsigned CTRL_RADIO_EN = 0;
   localparam int unsigned CTRL_TB_SET   = 1;
   localparam int unsigned CTRL_BOOTED   = 2;
   localparam logic [2:0]  CTRL_RESET    = 3'h1;                  // radio on, still in boot

   // irq bits
   localparam int unsigned IRQ_W        = 4;
   localparam int unsigned IRQ_TRIG     = 0;
   localparam int unsigned IRQ_REM_OUT  = 1;
   localparam int unsigned IRQ_REM_IN   = 2;
   localparam int unsigned IRQ_STOP     = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // types
   // ************************************************************
   // pattern states, gray along power-up path
   typedef enum logic [2:0] {
      SLS_WHITE = 3'b000,
      SLS_DARK  = 3'b001,
      SLS_RED   = 3'b011,
      SLS_GREEN = 3'b010
   } sls_mode_t;

   // card destination and overwrite control
   typedef struct packed {
      logic wr_int;      // write acquired data to internal card
      logic wr_rem;      // write acquired data to removable card
      logic ovw_int;     // overwrite internal absence-era data
   } sls_rec_t;

   // led drive
   typedef struct packed {
      logic r;
      logic g;
      logic b;
   } sls_rgb_t;

endpackage : sls_pkg

/* File: hw/sls_top.sv */
/*
 * status indicator sequencer: drives an rgb led with boot, card, lock,
 * heartbeat and trigger patterns, steers card recording and the radio gate.
 * assumes card detect, lock and button inputs are asynchronous pins and the
 * trigger pulse comes from logic on aclk; registers reached over AXI4-Lite.
 */
`timescale 1ns/1ps
module sls_top
   import sls_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        card_rem_det,
   input  wire logic        card_int_det,
   input  wire logic        time_lock_ok,
   input  wire logic        stop_btn,
   input  wire logic        trig_evt,
   output logic             led_r,
   output logic             led_g,
   output logic             led_b,
   output logic             rec_int_en,
   output logic             rec_rem_en,
   output logic             int_ovw,
   output logic             radio_svc_en,
   output logic             radio_pwr,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   logic [3:0] pin_prev_reg;
   logic       rem_s, int_s, lock_s, stop_s;

   // two sync flops and an edge-history flop per pin, first read only by the second; no reset, so the
   // edge history settles to the pins while reset is held: no false edge
   always_ff @(posedge aclk) begin
      pin_meta_reg <= {stop_btn, time_lock_ok, card_int_det, card_rem_det};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
   end
   assign rem_s  = pin_sync_reg[0];
   assign int_s  = pin_sync_reg[1];
   assign lock_s = pin_sync_reg[2];
   assign stop_s = pin_sync_reg[3];

   logic rem_fall, rem_rise, stop_rise;
   assign rem_fall  = pin_prev_reg[0] & ~rem_s;
   assign rem_rise  = ~pin_prev_reg[0] & rem_s;
   assign stop_rise = ~pin_prev_reg[3] & stop_s;

   // ************************************************************
   // registers over axi4-lite
   // ************************************************************
   logic [2:0]       ctrl_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [IRQ_W-1:0] irq_ev;
   logic             aw_hold_reg, w_hold_reg;
   logic [7:0]       awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             wr_fire, rd_fire;
   logic [IRQ_W-1:0] irq_clr;

   assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   // address and data captured separately, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_hold_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_hold_reg   <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write response; unmapped offsets answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_reg == OFS_CTRL || awaddr_reg == OFS_IRQ_EN ||
                          awaddr_reg == OFS_IRQ_CL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // radio service gate; ctrl and enable writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= CTRL_RESET;
         irq_en_reg <= '0;
      end else if (wr_fire && wstrb_reg[0]) begin
         if (awaddr_reg == OFS_CTRL)
            ctrl_reg <= wdata_reg[2:0];
         if (awaddr_reg == OFS_IRQ_EN)
            irq_en_reg <= wdata_reg[IRQ_W-1:0];
      end
   end

   assign irq_clr = (wr_fire && wstrb_reg[0] && awaddr_reg == OFS_IRQ_CL) ? wdata_reg[IRQ_W-1:0] : '0;
   assign irq_ev  = {stop_rise & ~rem_s, rem_rise, rem_fall, trig_evt};

   // sticky status and level irq; a new event beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_st_reg <= '0;
         irq        <= 1'b0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
         irq        <= |(irq_st_reg & irq_en_reg);
      end
   end

   sls_mode_t mode_reg;
   sls_rec_t  rec_reg;

   // read channel, one cycle to answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL:   s_axi_rdata <= {29'h0, ctrl_reg};
            OFS_STATUS: s_axi_rdata <= {22'h0, rec_reg, mode_reg, stop_s, lock_s, int_s, rem_s};
            OFS_IRQ_ST: s_axi_rdata <= {28'h0, irq_st_reg};
            OFS_IRQ_EN: s_axi_rdata <= {28'h0, irq_en_reg};
            OFS_IRQ_CL: s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************************
   // recording steering
   // ************************************************************
   logic stopped_reg;

   // stop latch only while the removable card is out
   always_ff @(posedge aclk) begin
      if (!aresetn)
         stopped_reg <= 1'b0;
      else if (rem_s)
         stopped_reg <= 1'b0;
      else if (stop_rise)
         stopped_reg <= 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rec_reg <= '0;
      end else begin
         rec_reg.wr_rem  <= rem_s;
         rec_reg.wr_int  <= int_s & ~(~rem_s & (stopped_reg | stop_rise));
         rec_reg.ovw_int <= rem_rise & int_s;
      end
   end
   assign rec_int_en = rec_reg.wr_int;
   assign rec_rem_en = rec_reg.wr_rem;
   assign int_ovw    = rec_reg.ovw_int;

   // module stays powered, only the service is gated
   always_ff @(posedge aclk) begin
      radio_svc_en <= aresetn & ctrl_reg[CTRL_RADIO_EN];
      radio_pwr    <= 1'b1;
   end

   // ************************************************************
   // pattern timebase and sequencer
   // ************************************************************
   localparam int unsigned DIV_W = $clog2(TICK_DIV + 1);
   logic [DIV_W-1:0] div_reg;
   logic             tick;
   logic [12:0]      ms_reg;
   logic [1:0]       flash_n;
   logic [12:0]      period_ms;

   assign tick = (div_reg == DIV_W'(TICK_DIV - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 1'b1;
   end

   // one pattern picked from card and lock flags
   always_comb begin
      flash_n = 2'd3;
      if (rem_s && !int_s)
         flash_n = 2'd1;                       // removable only
      else if (int_s && !rem_s)
         flash_n = 2'd2;                       // internal only
      else if (rem_s && int_s && !lock_s)
         flash_n = 2'd3;                       // no lock
   end

   logic red_case;
   assign red_case = ~(rem_s & int_s & lock_s);
   assign period_ms = (mode_reg == SLS_GREEN) ? 13'(GREEN_PER_MS) :
                      (mode_reg == SLS_WHITE) ? 13'(2 * WHITE_MS) :
                      13'(32'(flash_n) * (RED_ON_MS + RED_GAP_MS) + PAUSE_MS);

   // mode selection follows boot flags, then card and lock state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= SLS_WHITE;
      end else begin
         case (mode_reg)
            SLS_WHITE: if (ctrl_reg[CTRL_TB_SET]) mode_reg <= SLS_DARK;
            SLS_DARK:  if (ctrl_reg[CTRL_BOOTED]) mode_reg <= red_case ? SLS_RED : SLS_GREEN;
            SLS_RED:   if (!red_case) mode_reg <= SLS_GREEN;
            SLS_GREEN: if (red_case) mode_reg <= SLS_RED;
            default:   mode_reg <= SLS_WHITE;
         endcase
         if (!ctrl_reg[CTRL_TB_SET])
            mode_reg <= SLS_WHITE;
      end
   end

   // ms position inside the current pattern period
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ms_reg <= '0;
      else if (tick)
         ms_reg <= (ms_reg + 13'd1 >= period_ms) ? 13'd0 : ms_reg + 13'd1;
   end

   logic red_on;
   assign red_on = (ms_reg < 13'(32'(flash_n) * (RED_ON_MS + RED_GAP_MS))) &&
                   ((ms_reg % 13'(RED_ON_MS + RED_GAP_MS)) < 13'(RED_ON_MS));

   // blue flash length counter per trigger
   logic [8:0] blue_ms_reg;
   logic       blue_act_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blue_act_reg <= 1'b0;
         blue_ms_reg  <= '0;
      end else if (trig_evt) begin
         blue_act_reg <= 1'b1;
         blue_ms_reg  <= '0;
      end else if (blue_act_reg && tick) begin
         blue_ms_reg <= blue_ms_reg + 9'd1;
         if (blue_ms_reg == 9'(BLUE_ON_MS - 1))
            blue_act_reg <= 1'b0;
      end
   end

   // led drive from flops, one colour set per mode
   sls_rgb_t led_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         led_reg <= '0;
      end else begin
         case (mode_reg)
            SLS_WHITE: led_reg <= {3{ms_reg < 13'(WHITE_MS)}};
            SLS_RED:   led_reg <= '{r: red_on, g: 1'b0, b: blue_act_reg};
            SLS_GREEN: led_reg <= '{r: 1'b0, g: ms_reg < 13'(GREEN_ON_MS), b: blue_act_reg};
            // dark during boot and for stray codes
            default:   led_reg <= '0;
         endcase
      end
   end
   assign led_r = led_reg.r;
   assign led_g = led_reg.g;
   assign led_b = led_reg.b;

   // ************************************************************
   // assertions
   // ************************************************************
   AST_DARK_BOOT: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg == SLS_DARK |=> !led_r && !led_g && !led_b) else $error("led lit during boot");
   AST_WHITE: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg == SLS_WHITE |=> led_r == led_g && led_g == led_b) else $error("white pattern not white");
   AST_RED_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg != SLS_WHITE |=> !(led_r && led_g)) else $error("red and green together");
   AST_BLUE: assert property (@(posedge aclk) disable iff (!aresetn)
      trig_evt |=> blue_act_reg) else $error("trigger missed blue flash");
   AST_REC_INT: assert property (@(posedge aclk) disable iff (!aresetn)
      int_s && !rem_s && !stopped_reg && !stop_rise |=> rec_int_en) else $error("internal rec stopped");
   AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
      stopped_reg && !rem_s |=> !rec_int_en) else $error("stop ignored");
   AST_OVW: assert property (@(posedge aclk) disable iff (!aresetn)
      rem_rise && int_s |=> int_ovw ##1 !int_ovw) else $error("overwrite strobe wrong");
   AST_RADIO: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 radio_pwr) else $error("radio power dropped");
   AST_GREEN: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg == SLS_RED |=> !led_g) else $error("green in red mode");
   AST_RED_N: assert property (@(posedge aclk) disable iff (!aresetn)
      rem_s && !int_s |-> flash_n == 2'd1) else $error("wrong flash count");
   COV_GREEN: cover property (@(posedge aclk) mode_reg == SLS_GREEN);
   COV_BLUE:  cover property (@(posedge aclk) led_b && mode_reg == SLS_GREEN);
   COV_STOP:  cover property (@(posedge aclk) stopped_reg);

endmodule : sls_top

/* File: testbench/sls_led_model.sv */
/* led model: counts flashes of each colour, red groups and the green period.
   assumes active-high led drives that change on aclk edges. */
`timescale 1ns/1ps
module sls_led_model #(
   parameter int unsigned GAP = 2000
) (
   input  wire logic aclk,
   input  wire logic led_r,
   input  wire logic led_g,
   input  wire logic led_b,
   output int        n_w,
   output int        n_r,
   output int        n_g,
   output int        n_b,
   output int        grp,
   output int        grp_n,
   output int        g_t
);
   bit pr, pg, pb;
   int run, dark, gcyc;
   // ********
   // edge counts; a long dark spell closes a red group
   // ********
   always @(posedge aclk) begin
      pr <= led_r;
      pg <= led_g;
      pb <= led_b;
      gcyc <= gcyc + 1;
      dark <= led_r ? 0 : dark + 1;
      if (led_r && led_g && led_b && !(pr && pg && pb)) begin
         n_w <= n_w + 1; // white is all three at once
      end else begin
         if (led_r && !pr) begin
            n_r <= n_r + 1;
            run <= run + 1;
         end
         if (led_g && !pg) begin
            n_g <= n_g + 1;
            g_t <= gcyc;
            gcyc <= 1; // this edge's cycle counts towards the next period
         end
         if (led_b && !pb) n_b <= n_b + 1;
      end
      // gap must beat red spacing but not the pause
      if (dark == GAP && run != 0) begin
         grp_n <= run;
         grp <= grp + 1;
         run <= 0;
      end
   end
endmodule : sls_led_model

/* File: testbench/tb_status_led_sequencer.sv */
/* bench for the status sequencer: axi-lite master, pin stimulus, led model.
   assumes TICK_DIV of 4 cycles per ms so pattern waits stay short. */
`timescale 1ns/1ps
module tb_status_led_sequencer;
   import sls_pkg::*;
   localparam int unsigned TD = 4;
   logic aclk, aresetn, card_rem_det, card_int_det, time_lock_ok, stop_btn, trig_evt;
   logic led_r, led_g, led_b, rec_int_en, rec_rem_en, int_ovw, radio_svc_en, radio_pwr, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int n_w, n_r, n_g, n_b, grp, grp_n, g_t, errors, compares, n_ovw, s;
   sls_top #(.TICK_DIV(TD)) sls_top_inst (.*);
   sls_led_model #(.GAP(2000)) sls_led_model_inst (.*);
   always #20 aclk = ~aclk;
   always @(posedge aclk) if (int_ovw === 1'b1) n_ovw <= n_ovw + 1;
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic hang();
      errors++;
      test_done();
   endtask : hang
   // write; both channels offered together, released on their own handshakes
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      if (k == 200) hang();
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      if (k == 200) hang();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : axr
   // bounded wait on the model's group or green count
   task automatic wt(input bit g, input int tgt);
      int k;
      for (k = 0; k < 40000 && (g ? n_g : grp) < tgt; k++) @(posedge aclk);
      if (k == 40000) hang();
   endtask : wt
   // ********
   // scenarios
   // ********
   task automatic t_boot();
      axr(OFS_CTRL);
      chk(d, 32'h1, "ctrl reset");
      chk(radio_pwr, 1'b1, "radio power");
      repeat (500) @(posedge aclk);
      chk(n_w != 0, 1'b1, "white flashing");
      axw(OFS_CTRL, 32'h3);
      chk(r, RESP_OKAY, "ctrl write resp");
      repeat (20) @(posedge aclk);
      s = n_w + n_r + n_g + n_b;
      repeat (1000) @(posedge aclk);
      chk(n_w + n_r + n_g + n_b, s, "dark flashes");
      chk({led_r, led_g, led_b}, 3'h0, "dark leds");
   endtask : t_boot
   task automatic t_red();
      logic [2:0] pin [3] = '{3'b101, 3'b011, 3'b110};
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         {card_rem_det, card_int_det, time_lock_ok} <= pin[i];
         if (i == 0) axw(OFS_CTRL, 32'h7);
         wt(0, grp + 2);
         chk(grp_n, i + 1, "red group");
      end
   endtask : t_red
   task automatic t_green();
      @(posedge aclk);
      time_lock_ok <= 1;
      wt(1, n_g + 1);
      s = n_r;
      wt(1, n_g + 1);
      chk(g_t, GREEN_PER_MS * TD, "green period");
      chk(n_r, s, "red in green");
      axr(OFS_STATUS);
      chk(d[9:0], {3'b110, SLS_GREEN, 4'b0111}, "status green");
   endtask : t_green
   task automatic t_trig();
      axw(OFS_IRQ_EN, 32'h0);
      s = n_b;
      trig_evt <= 1;
      @(posedge aclk);
      trig_evt <= 0;
      repeat (3) @(posedge aclk);
      chk(led_b, 1'b1, "blue on");
      chk(irq, 1'b0, "irq masked");
      axr(OFS_IRQ_ST);
      chk(d[IRQ_TRIG], 1'b1, "trig status");
      axw(OFS_IRQ_EN, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1, "irq raised");
      axw(OFS_IRQ_CL, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0, "irq cleared");
      repeat (1300) @(posedge aclk);
      chk(n_b, s + 1, "blue count");
   endtask : t_trig
   task automatic t_rec();
      card_rem_det <= 0;
      repeat (8) @(posedge aclk);
      chk({rec_int_en, rec_rem_en}, 2'b10, "card out rec");
      s = n_ovw;
      card_rem_det <= 1;
      repeat (10) @(posedge aclk);
      chk(n_ovw, s + 1, "overwrite pulse");
      card_rem_det <= 0;
      repeat (8) @(posedge aclk);
      stop_btn <= 1;
      repeat (8) @(posedge aclk);
      stop_btn <= 0;
      chk(rec_int_en, 1'b0, "stop rec");
      axr(OFS_IRQ_ST);
      chk(d[3:0], 4'he, "card irq status");
      card_rem_det <= 1;
   endtask : t_rec
   task automatic t_radio();
      axw(OFS_CTRL, 32'h6);
      repeat (2) @(posedge aclk);
      chk({radio_svc_en, radio_pwr}, 2'b01, "radio off powered");
      axr(8'h20);
      chk(d, 32'h0, "unmapped read data");
      chk(r, RESP_SLVERR, "unmapped read resp");
      axw(OFS_STATUS, 32'h0);
      chk(r, RESP_SLVERR, "status write resp");
   endtask : t_radio
   // ********
   // main sequence
   // ********
   initial begin
      aclk = 0; aresetn = 0; trig_evt = 0; stop_btn = 0;
      card_rem_det = 0; card_int_det = 0; time_lock_ok = 0;
      s_axi_awaddr = 8'h0; s_axi_awvalid = 0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
      s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 8'h0; s_axi_arvalid = 0; s_axi_rready = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_boot();
      t_red();
      t_green();
      t_trig();
      t_rec();
      t_radio();
      test_done();
   end
endmodule : tb_status_led_sequencer
